// [rtl/tsm_pkg.sv]
// constants and carrier types for the switch control memory block
// -----------------------------------------------------------------
// Summary of operation
// - control register writes finish fast; every memory access is slow
// - memory and stream for channel accesses come from control register
// - split bit set: channel reads hit data memory, writes hit low memory
// - split bit clear: reads and writes use the memory select field
// - stream field picks the memory subsection in either split setting
// - global processor mode sends low memory on every channel
// - processor mode off: each channel follows its own memory bits
// - select 01 data memory read only, 10 low, 11 high; 00 unused
// - three bit stream field names the stream subsection in binary
// - upper five bits of high memory read back as zero
// - source bit set: low memory value is sent on the channel
// - source bit clear: low memory addresses data memory byte to send
// - external control bit leaves one channel ahead of its channel
// - external control bits within a slot go out stream 0 first
// - enable bit used only with drive pin high and processor mode off
// - low memory bits 7-5 give the source stream
// - low memory bits 4-0 give the source channel, bit 4 msb
// - source bit or processor mode: all 8 low bits sent literally
// - drive pin low puts every serial output except external control in high impedance
// - top address line low reaches control, high picks one of 32
// - processor mode acts as if source and enable bits were one
// -----------------------------------------------------------------
package tsm_pkg;
  // control register fields
  localparam int CTRL_SPLIT = 7;
  localparam int CTRL_PMODE = 6;
  localparam int CTRL_SEL_HI = 4;
  localparam int CTRL_SEL_LO = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hdf; // bit 5 holds nothing
  // memory select codes
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h2;
  localparam logic [1:0] SEL_HIGH = 2'h3;
  // high memory fields
  localparam int HI_SRC = 2;
  localparam int HI_XCTL = 1;
  localparam int HI_OE = 0;
  // address pins
  localparam int ADDR_REGION = 5;
  // serial clock counter: half bit, bit in channel, channel
  localparam int CNT_W = 9;
  localparam logic [3:0] SLOT_START = 4'h0;

  typedef struct packed {
    logic [2:0] stream;
    logic [4:0] channel;
    logic [7:0] data;
    logic drive;
  } tsm_word_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_ACK = 3'b100
  } tsm_bus_t;
endpackage

// [rtl/tsm_switch_ctrl.sv]
// control register, connection memories and output word sequencer
`timescale 1ns/100ps
module tsm_switch_ctrl #(
  parameter int STREAMS = 8,
  parameter int CHANNELS = 32
) (
  input wire logic clk, // 20 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic bus_cs_n, // chip select pin, active low
  input wire logic bus_rw, // 1 read, 0 write
  input wire logic [5:0] bus_addr, // address pins
  input wire logic [7:0] bus_data_i, // data pins, inbound
  output logic [7:0] bus_data_o, // data pins, outbound
  output logic bus_data_oe, // data pins driven
  output logic transfer_acknowledge_n_o, // ack pin level
  output logic transfer_acknowledge_oe, // ack pin pulled low
  input wire logic serial_clock_4m, // serial clock pin
  input wire logic frame_pulse_n, // frame pulse pin, active low
  input wire logic master_drive_pin, // master output drive pin
  input wire logic dm_wr_en, // received byte strobe
  input wire logic [7:0] dm_wr_idx, // stream and channel of it
  input wire logic [7:0] dm_wr_byte, // received byte
  output tsm_pkg::tsm_word_t out_word, // next channel word
  output logic out_valid, // out_word holds a word
  input wire logic out_ready, // converter takes the word
  output logic external_control_bit_o // external control serial bit
);
  // the index and counter slices serve only the full 8 x 32 map
  if (STREAMS != 8 || CHANNELS != 32) begin : g_size_check
    $error("only 8 streams of 32 channels are served");
  end

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [18:0] pin_s1_q;
  logic [18:0] pin_s2_q;
  logic c4_prev_q;
  // two flops per pin; only the second stage feeds logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 19'h00001;
      pin_s2_q <= 19'h00001;
    end else begin
      pin_s1_q <= {master_drive_pin, frame_pulse_n, serial_clock_4m,
                   bus_data_i, bus_addr, bus_rw, bus_cs_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  logic cs_s;
  logic rw_s;
  logic [5:0] addr_s;
  logic [7:0] wdat_s;
  logic c4_s;
  logic fp_n_s;
  logic mdrv_s;
  assign cs_s = ~pin_s2_q[0];
  assign rw_s = pin_s2_q[1];
  assign addr_s = pin_s2_q[7:2];
  assign wdat_s = pin_s2_q[15:8];
  assign c4_s = pin_s2_q[16];
  assign fp_n_s = pin_s2_q[17];
  assign mdrv_s = pin_s2_q[18];

  // -----------------------------------------------------------------
  // frame timing from the serial clock
  // -----------------------------------------------------------------
  logic [tsm_pkg::CNT_W-1:0] cnt_q;
  logic c4_fall;
  logic slot_tick;
  logic bit_tick;
  assign c4_fall = c4_prev_q & ~c4_s;
  // slot and bit edges fall on the count value just taken
  assign slot_tick = c4_fall & (cnt_q[3:0] == tsm_pkg::SLOT_START);
  assign bit_tick = c4_fall & ~cnt_q[0];

  // frame pulse restarts the count; 512 serial clocks per frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c4_prev_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      c4_prev_q <= c4_s;
      if (c4_fall) begin
        cnt_q <= fp_n_s ? cnt_q + 1'b1 : '0;
      end
    end
  end

  // -----------------------------------------------------------------
  // memories and control register
  // -----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] cml_mem [256];
  logic [2:0] cmh_mem [256];
  logic [7:0] dm_mem [256];
  logic split;
  logic pmode;
  logic [1:0] sel;
  logic [7:0] bus_idx;
  assign split = ctrl_q[tsm_pkg::CTRL_SPLIT];
  assign pmode = ctrl_q[tsm_pkg::CTRL_PMODE];
  assign sel = ctrl_q[tsm_pkg::CTRL_SEL_HI:tsm_pkg::CTRL_SEL_LO];
  // stream from the control register, channel from the pins
  assign bus_idx = {ctrl_q[2:0], addr_s[4:0]};

  tsm_pkg::tsm_bus_t st_q;
  logic do_fast;
  logic do_slow;
  logic wr_low;
  logic wr_high;
  assign do_fast = (st_q == tsm_pkg::BUS_IDLE) & cs_s
                   & ~addr_s[tsm_pkg::ADDR_REGION];
  // a chip select dropped at the slot edge aborts with no write
  assign do_slow = (st_q == tsm_pkg::BUS_WAIT) & cs_s
                   & slot_tick;
  // split mode steers writes to low memory whatever the select says
  assign wr_low = do_slow & ~rw_s
                  & (split | sel == tsm_pkg::SEL_LOW);
  assign wr_high = do_slow & ~rw_s & ~split
                   & (sel == tsm_pkg::SEL_HIGH);

  // control register, written only by the fast path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= tsm_pkg::CTRL_RESET;
    end else if (do_fast & ~rw_s) begin
      ctrl_q <= wdat_s & tsm_pkg::CTRL_WMASK;
    end
  end

  // connection memories have no reset: drive pin guards power up
  always_ff @(posedge clk) begin
    if (wr_low) begin
      cml_mem[bus_idx] <= wdat_s;
    end
    if (wr_high) begin
      cmh_mem[bus_idx] <= wdat_s[2:0];
    end
  end

  // data memory is filled only by the receive side; bus may read it
  always_ff @(posedge clk) begin
    if (dm_wr_en) begin
      dm_mem[dm_wr_idx] <= dm_wr_byte;
    end
  end

  // -----------------------------------------------------------------
  // processor bus handshake
  // -----------------------------------------------------------------
  logic [7:0] rd_val;
  // read source: split forces data memory, else the select field
  always_comb begin
    rd_val = 8'h00;
    if (split) begin
      rd_val = dm_mem[bus_idx];
    end else begin
      case (sel)
        tsm_pkg::SEL_DATA: rd_val = dm_mem[bus_idx];
        tsm_pkg::SEL_LOW: rd_val = cml_mem[bus_idx];
        tsm_pkg::SEL_HIGH: rd_val = {5'h00, cmh_mem[bus_idx]};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // slow accesses sit in wait until a channel slot edge frees memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= tsm_pkg::BUS_IDLE;
      bus_data_o <= 8'h00;
      bus_data_oe <= 1'b0;
      transfer_acknowledge_n_o <= 1'b1;
      transfer_acknowledge_oe <= 1'b0;
    end else begin
      case (st_q)
        tsm_pkg::BUS_IDLE: begin
          if (do_fast) begin
            st_q <= tsm_pkg::BUS_ACK;
            bus_data_o <= ctrl_q & tsm_pkg::CTRL_WMASK;
            bus_data_oe <= rw_s;
            transfer_acknowledge_n_o <= 1'b0;
            transfer_acknowledge_oe <= 1'b1;
          end else if (cs_s) begin
            st_q <= tsm_pkg::BUS_WAIT;
          end
        end
        tsm_pkg::BUS_WAIT: begin
          if (~cs_s) begin
            st_q <= tsm_pkg::BUS_IDLE;
          end else if (do_slow) begin
            st_q <= tsm_pkg::BUS_ACK;
            bus_data_o <= rd_val;
            bus_data_oe <= rw_s;
            transfer_acknowledge_n_o <= 1'b0;
            transfer_acknowledge_oe <= 1'b1;
          end
        end
        tsm_pkg::BUS_ACK: begin
          if (~cs_s) begin
            st_q <= tsm_pkg::BUS_IDLE;
            bus_data_oe <= 1'b0;
            transfer_acknowledge_n_o <= 1'b1;
            transfer_acknowledge_oe <= 1'b0;
          end
        end
        default: st_q <= tsm_pkg::BUS_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // output word sequencer, one channel ahead of the serial stream
  // -----------------------------------------------------------------
  logic gen_busy_q;
  logic [2:0] gen_str_q;
  logic [4:0] gen_ch_q;
  logic [7:0] gen_idx;
  logic [7:0] gen_low;
  logic [2:0] gen_hi;
  logic use_lit;
  logic buf_in_ready;
  logic push;
  tsm_pkg::tsm_word_t push_word;
  assign gen_idx = {gen_str_q, gen_ch_q};
  assign gen_low = cml_mem[gen_idx];
  assign gen_hi = cmh_mem[gen_idx];
  // processor mode forces source and enable bits to one
  assign use_lit = pmode | gen_hi[tsm_pkg::HI_SRC];
  assign push = gen_busy_q & buf_in_ready;

  // literal byte, or low memory as stream 7-5 and channel 4-0 address
  always_comb begin
    push_word.stream = gen_str_q;
    push_word.channel = gen_ch_q;
    push_word.data = use_lit ? gen_low
                   : dm_mem[{gen_low[7:5], gen_low[4:0]}];
    push_word.drive = mdrv_s
                    & (pmode | gen_hi[tsm_pkg::HI_OE]);
  end

  // eight words per slot, stream 0 first, for the following channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gen_busy_q <= 1'b0;
      gen_str_q <= 3'h0;
      gen_ch_q <= 5'h00;
    end else if (slot_tick) begin
      gen_busy_q <= 1'b1;
      gen_str_q <= 3'h0;
      gen_ch_q <= cnt_q[8:4] + 5'h01;
    end else if (push) begin
      gen_str_q <= gen_str_q + 3'h1;
      gen_busy_q <= (gen_str_q != 3'h7);
    end
  end

  // -----------------------------------------------------------------
  // two-entry buffer toward the serial converter
  // -----------------------------------------------------------------
  tsm_pkg::tsm_word_t buf_q [2];
  logic [1:0] buf_cnt_q;
  logic pop;
  assign pop = out_valid & out_ready;
  // a stalled converter holds the sequencer; the next slot edge drops any words of the slot not yet pushed into the buffer
  assign buf_in_ready = (buf_cnt_q != 2'h2) | pop;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      buf_cnt_q <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      if (pop) begin
        buf_q[0] <= (buf_cnt_q == 2'h2) ? buf_q[1] : push_word;
      end else if (push & buf_cnt_q == 2'h0) begin
        buf_q[0] <= push_word;
      end
      if (push & (buf_cnt_q - {1'b0, pop}) == 2'h1) begin
        buf_q[1] <= push_word;
      end
      buf_cnt_q <= buf_cnt_q + {1'b0, push} - {1'b0, pop};
      out_valid <= (buf_cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end
  assign out_word = buf_q[0];

  // -----------------------------------------------------------------
  // external control serial bit, one channel early
  // -----------------------------------------------------------------
  logic [7:0] xc_idx;
  assign xc_idx = {cnt_q[3:1], cnt_q[8:4] + 5'h01};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      external_control_bit_o <= 1'b0;
    end else if (bit_tick) begin
      external_control_bit_o <= cmh_mem[xc_idx][tsm_pkg::HI_XCTL];
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  fast_ack_a: assert property (do_fast |=> !transfer_acknowledge_n_o)
    else $error("control access not acked next cycle");
  slow_wait_a: assert property ((st_q == tsm_pkg::BUS_IDLE) & cs_s
      & addr_s[tsm_pkg::ADDR_REGION] |=> transfer_acknowledge_n_o
      & (st_q == tsm_pkg::BUS_WAIT))
    else $error("memory access acked without slot wait");
  slot_ack_a: assert property (do_slow |=> transfer_acknowledge_oe
      & (bus_data_oe == $past(rw_s)))
    else $error("slow access not acked at slot edge");
  hi_zero_a: assert property (do_slow & rw_s & ~split
      & sel == tsm_pkg::SEL_HIGH |=> bus_data_o[7:3] == 5'h00)
    else $error("high memory upper bits not zero");
  split_rd_a: assert property (do_slow & rw_s & split
      |=> bus_data_o == $past(dm_mem[bus_idx]))
    else $error("split read not from data memory");
  drive_off_a: assert property (push & ~mdrv_s |-> !push_word.drive)
    else $error("channel driven with drive pin low");
  pmode_lit_a: assert property (push & pmode
      |-> push_word.data === gen_low && push_word.drive === mdrv_s)
    else $error("processor mode word not literal");
  // case equality: unprogrammed memory words carry no value yet
  xctl_bit_a: assert property (bit_tick
      |=> external_control_bit_o
      === $past(cmh_mem[xc_idx][tsm_pkg::HI_XCTL]))
    else $error("external control bit wrong");
  buf_full_a: assert property (buf_cnt_q == 2'h2 & ~out_ready
      |-> !buf_in_ready)
    else $error("buffer accepts while full");

  slow_read_c: cover property (do_slow & rw_s);
  fast_write_c: cover property (do_fast & ~rw_s);
  buf_full_c: cover property (buf_cnt_q == 2'h2);
  pmode_push_c: cover property (push & pmode & mdrv_s);
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the switch control memory block
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, sclk = 1'b0, drive = 1'b1, ready = 1'b1;
  logic dm_en = 1'b0, valid, ack_n, ack_oe, doe, xbit;
  logic cs_n, rw;
  logic [5:0] addr;
  logic [7:0] wd, rd, dm_idx = 8'h00, dm_byte = 8'h00, q;
  wire logic ack_line_n = ack_oe ? ack_n : 1'b1; // pull-up
  tsm_pkg::tsm_word_t word, w;
  int miscompares = 0, checks_done = 0, cycles = 0, lat;
  always #25 clk = ~clk;
  always #122 sclk = ~sclk; // serial clock, free phase
  tsm_host_model host (.clk(clk), .cs_n(cs_n), .rw(rw), .addr(addr),
    .wdata(wd), .rdata(rd), .rdata_oe(doe), .ack_line_n(ack_line_n));
  tsm_switch_ctrl uut (.clk(clk), .rst(rst), .bus_cs_n(cs_n),
    .bus_rw(rw), .bus_addr(addr), .bus_data_i(wd), .bus_data_o(rd),
    .bus_data_oe(doe), .transfer_acknowledge_n_o(ack_n),
    .transfer_acknowledge_oe(ack_oe), .serial_clock_4m(sclk),
    .frame_pulse_n(1'b1), .master_drive_pin(drive), .dm_wr_en(dm_en),
    .dm_wr_idx(dm_idx), .dm_wr_byte(dm_byte), .out_word(word),
    .out_valid(valid), .out_ready(ready), .external_control_bit_o(xbit));
  // ------------------------------------------------------------
  // comparison, closing report and hang guard
  // ------------------------------------------------------------
  task automatic check(string name, logic [16:0] seen, logic [16:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      results();
    end
  end
  // short bus helpers
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, q, lat);
  endtask
  task automatic rdb(input logic [5:0] a);
    host.xfer(1'b1, a, 8'h00, q, lat);
  endtask
  // second matching word: the first may predate the new settings
  task automatic get_word;
    int n, i;
    n = 0;
    w = '0;
    for (i = 0; i < 6000 && n < 2; i++) begin
      @(posedge clk);
      if (valid === 1'b1 && word.stream === 3'h3 &&
          word.channel === 5'h05) begin
        n++;
        w = word;
      end
    end
    check("word_found", n, 2);
  endtask
  // after the stream 3 channel 5 word, watch one channel of control bits
  task automatic scan_xbit(output int first, output int ones);
    int i;
    first = -1;
    ones = 0;
    get_word();
    for (i = 0; i < 78; i++) begin
      @(posedge clk);
      if (xbit === 1'b1) begin
        ones++;
        if (first < 0) first = i;
      end
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_ctrl;
    wr(6'h1f, 8'hbf); // any address with the top line low
    check("ctrl_fast", lat > 0 && lat <= 4, 1);
    rdb(6'h00);
    check("ctrl_read", q, 8'h9f);
    wr(6'h00, 8'h00);
    $display("test ctrl done");
  endtask
  task automatic t_mem;
    wr(6'h00, 8'h13); // low memory, stream 3
    wr(6'h25, 8'ha5);
    check("slow_wr", lat > 4, 1);
    wr(6'h00, 8'h1b); // high memory, stream 3
    wr(6'h25, 8'hff);
    rdb(6'h25);
    check("high_read", q, 8'h07);
    wr(6'h00, 8'h12); // other stream must not alias
    wr(6'h25, 8'h11);
    wr(6'h00, 8'h13);
    rdb(6'h25);
    check("low_read", q, 8'ha5);
    check("slow_ack", lat > 4, 1);
    wr(6'h00, 8'h03); // select 00 write ignored
    wr(6'h25, 8'h77);
    wr(6'h00, 8'h13);
    rdb(6'h25);
    check("sel00_ign", q, 8'ha5);
    $display("test mem done");
  endtask
  task automatic t_split;
    @(posedge clk);
    #1;
    dm_en = 1'b1;
    dm_idx = 8'h65;
    dm_byte = 8'h3c;
    @(posedge clk);
    #1;
    dm_en = 1'b0;
    wr(6'h00, 8'h0b); // data memory stream 3, split off
    rdb(6'h25);
    check("dm_read", q, 8'h3c);
    wr(6'h00, 8'h8b); // split on
    rdb(6'h25);
    check("split_rd", q, 8'h3c);
    wr(6'h25, 8'h66);
    wr(6'h00, 8'h13);
    rdb(6'h25);
    check("split_wr", q, 8'h66);
    $display("test split done");
  endtask
  task automatic t_words;
    #1;
    ready = 1'b0; // stall the converter side
    repeat (200) @(posedge clk);
    check("stall_hold", valid, 1);
    #1;
    ready = 1'b1;
    wr(6'h00, 8'h1b);
    wr(6'h25, 8'h05); // source literal, enable
    get_word();
    check("literal", w, {3'h3, 5'h05, 8'h66, 1'b1});
    wr(6'h25, 8'h02); // data memory source, disabled
    wr(6'h00, 8'h13);
    wr(6'h25, 8'h65); // source stream 3 channel 5
    get_word();
    check("switched", w, {3'h3, 5'h05, 8'h3c, 1'b0});
    wr(6'h00, 8'h5b); // processor mode on
    get_word();
    check("pmode", w, {3'h3, 5'h05, 8'h65, 1'b1});
    #1;
    drive = 1'b0;
    get_word();
    check("drive_off", w.drive, 0);
    #1;
    drive = 1'b1;
    wr(6'h00, 8'h1b);
    get_word();
    check("pmode_off", w.drive, 0);
    $display("test words done");
  endtask
  // bit 3 of the slot before channel 5 carries stream 3's control bit
  task automatic t_xctl;
    int first, ones;
    wr(6'h00, 8'h1b); // high memory, stream 3
    wr(6'h25, 8'h02); // external control bit set
    scan_xbit(first, ones);
    check("xctl_pos", first >= 20 && first <= 32, 1);
    check("xctl_len", ones >= 9 && ones <= 10, 1);
    wr(6'h25, 8'h05); // external control bit clear
    scan_xbit(first, ones);
    check("xctl_clr", ones, 0);
    $display("test xctl done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_ctrl();
    t_mem();
    t_split();
    t_words();
    t_xctl();
    results();
  end
endmodule

// [testbench/tsm_host_model.sv]
// host processor model driving the parallel bus of the switch
`timescale 1ns/100ps
module tsm_host_model (
  input wire logic clk, // system clock
  output logic cs_n, // chip select, active low
  output logic rw, // 1 read, 0 write
  output logic [5:0] addr, // address lines
  output logic [7:0] wdata, // data lines toward device
  input wire logic [7:0] rdata, // device data lines
  input wire logic rdata_oe, // device drives data lines
  input wire logic ack_line_n // resolved ack line, pulled up
);
  initial begin
    cs_n = 1'b1;
    rw = 1'b1;
    addr = 6'h00;
    wdata = 8'h00;
  end
  // ------------------------------------------------------------
  // one transfer, held until ack is seen at a rising edge
  // ------------------------------------------------------------
  // released data lines show the inverse so a stale value never matches
  task automatic xfer(input logic r, input logic [5:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output int lat);
    int n;
    lat = -1;
    q = 8'h00;
    @(posedge clk);
    #1;
    cs_n = 1'b0;
    rw = r;
    addr = a;
    wdata = r ? ~wdata : d;
    for (n = 1; n < 300; n++) begin
      @(posedge clk);
      if (ack_line_n === 1'b0) begin
        lat = n;
        q = rdata_oe ? rdata : ~rdata;
        break;
      end
    end
    #1;
    cs_n = 1'b1; // next request only after cs high is seen
    wdata = ~wdata;
    for (n = 0; n < 10 && ack_line_n !== 1'b1; n++) @(posedge clk);
  endtask
endmodule
